// File: hdl/dram_ctrl_cfg.svh
`ifndef DRAM_CTRL_CFG_SVH
`define DRAM_CTRL_CFG_SVH

// clock rate
`define CORE_CLK_MHZ          250
// -12 speed grade timing, ns
`define T_RAS_NS              120
`define T_RP_NS               90
`define T_RCD_NS              25
`define T_CAS_NS              30
`define T_ASR_MUX_NS          10
// derived cycle counts: least times round up
`define CYC_OF(ns)            (((ns) * `CORE_CLK_MHZ + 999) / 1000)
`define RAS_CYC               `CYC_OF(`T_RAS_NS)
`define RP_CYC                `CYC_OF(`T_RP_NS)
`define RCD_CYC               `CYC_OF(`T_RCD_NS)
`define CAS_CYC               `CYC_OF(`T_CAS_NS)
`define MUX_CYC               `CYC_OF(`T_ASR_MUX_NS)
// burst refresh
`define BURST_ROWS            512
`define BURST_INTERVAL_MS     4
// refresh row counter
`define ROW_BITS              9
`define ROW_RESET             9'h000

`endif

// File: hdl/dram_ctrl_pkg.sv
package dram_ctrl_pkg;

  typedef enum logic [2:0] {
    CYC_READ  = 3'b001,
    CYC_WRITE = 3'b010,
    CYC_RMW   = 3'b100
  } cycle_kind_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic row_addr_gate;
    logic col_addr_gate;
    logic refresh_active;
  } dram_strobes_t;

endpackage

// File: hdl/async_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module async_sync3 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // asynchronous level in
  input  wire logic async_in,
  // filtered level and its rising edge
  output logic      level,
  output logic      rise
);

  logic [2:0] stage;

  // stage[0] feeds stage[1] only; change accepted once [1] and [2] agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (stage[2] == stage[1] && level != stage[2]) begin
        level <= stage[2];
        rise  <= stage[2];
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/dram_refresh_arbiter_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

`include "dram_ctrl_cfg.svh"

// Overview of operation
// - both intermittent single refreshes and whole-sweep burst refresh are supported.
// - in burst mode, each request runs 512 refreshes back to back, no cpu access.
// - in intermittent mode, each request steals one cycle between cpu cycles.
// - cpu and refresh requests arrive asynchronously, refresh from unrelated oscillator.
// - each started memory cycle is decided as cpu access or refresh.
// - refresh granted at once whenever the sequencer is idle, even with a cpu request waiting.
// - cpu request during refresh waits until the refresh has fully completed.
// - refresh request during a cpu cycle waits until that cycle ends.
// - postponed refresh is latched and granted automatically afterwards, never lost.
// - simultaneous refresh and cpu requests grant refresh first.
// - read, write and read-modify-write cpu cycles are executed.
// - all cycle timings sized for -12 speed grade parts.
// - address mux presents row first, then switches to column.
// - ras, cas and we are driven in dram order with the address switch.
// - memory_ack tells cpu the access is done; cpu waits for it.
// - refresh is ras-only: refresh row shown, ras pulsed, cas held off.
// - priority is current cycle, then pending refresh, then cpu request.
// - rmw_cycle_select picks read-modify-write versus plain read or write.
// - separate row and column address gate outputs drive the address bus.
// - refresh_active is asserted through each refresh, selecting refresh row address.
module dram_refresh_arbiter_sequencer #(
  parameter int ROW_BITS    = `ROW_BITS,
  parameter int BURST_ROWS  = `BURST_ROWS
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // processor side
  input  wire logic                  cpu_mem_request,
  input  wire logic                  cpu_write,
  input  wire logic                  rmw_cycle_select,
  input  wire logic                  rmw_write_go,
  output logic                       memory_ack,
  // refresh source and mode
  input  wire logic                  refresh_request_tick,
  input  wire logic                  burst_mode,
  // dram side
  output dram_ctrl_pkg::dram_strobes_t dram,
  output logic [ROW_BITS-1:0]        refresh_row
);

  localparam int RAS_C = `RAS_CYC;
  localparam int RP_C  = `RP_CYC;
  localparam int RCD_C = `RCD_CYC;
  localparam int CAS_C = `CAS_CYC;
  localparam int MUX_C = `MUX_CYC;
  localparam logic [7:0] RAS_C8 = 8'(RAS_C);
  localparam logic [7:0] RP_C8  = 8'(RP_C);
  localparam logic [7:0] RCD_C8 = 8'(RCD_C);
  localparam logic [7:0] CAS_C8 = 8'(CAS_C);
  localparam logic [7:0] MUX_C8 = 8'(MUX_C);
  localparam logic [9:0] BURST_LAST = 10'(BURST_ROWS - 1);
  // ack state pads a plain cpu cycle out to the minimum ras low time
  localparam int ACK_MIN = RAS_C - MUX_C - RCD_C - CAS_C - 4;
  localparam logic [7:0] ACK_C8 = 8'((ACK_MIN > 0) ? ACK_MIN : 0);

  typedef enum logic [7:0] {
    ST_IDLE    = 8'b0000_0001,
    ST_ROW     = 8'b0000_0010,
    ST_COL     = 8'b0000_0100,
    ST_CAS     = 8'b0000_1000,
    ST_RMW_WR  = 8'b0001_0000,
    ST_ACK     = 8'b0010_0000,
    ST_REFRESH_ACTIVE    = 8'b0100_0000,
    ST_PRECHG  = 8'b1000_0000
  } seq_state_t;

  seq_state_t              state;
  logic [7:0]              timer;
  logic                    cpu_level;
  logic                    tick_rise;
  logic                    refresh_pending;
  logic [9:0]              burst_left;
  logic                    in_refresh;
  dram_ctrl_pkg::cycle_kind_t kind;
  logic                    start_refresh;
  logic                    start_cpu;
  logic                    timer_done;

  // three flip-flop synchronisers on both asynchronous inputs
  async_sync3 u_sync_cpu (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (cpu_mem_request),
    .level    (cpu_level),
    .rise     ()
  );

  async_sync3 u_sync_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (refresh_request_tick),
    .level    (),
    .rise     (tick_rise)
  );

  assign timer_done = (timer == 8'h00);

  // arbitration: refresh beats a new cpu request; a running cycle is never preempted
  assign start_refresh = (state == ST_IDLE) && (refresh_pending || tick_rise || burst_left != 10'h000);
  assign start_cpu     = (state == ST_IDLE) && !start_refresh && cpu_level && !memory_ack;

  // pending refresh flag; a tick in the clearing cycle is kept unless it is the one served now
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_pending <= 1'b0;
    end else if (tick_rise && !(start_refresh && !refresh_pending && burst_left == 10'h000)) begin
      refresh_pending <= 1'b1;
    end else if (start_refresh && burst_left == 10'h000) begin
      refresh_pending <= 1'b0;
    end
  end

  // burst sweep counter: one tick buys a full sweep of rows
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_left <= 10'h000;
    end else if (start_refresh && burst_left == 10'h000 && burst_mode) begin
      burst_left <= BURST_LAST;
    end else if (start_refresh && burst_left != 10'h000) begin
      burst_left <= burst_left - 10'h001;
    end
  end

  // main sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      timer      <= 8'h00;
      in_refresh <= 1'b0;
      kind       <= dram_ctrl_pkg::CYC_READ;
    end else begin
      if (!timer_done) begin
        timer <= timer - 8'h01;
      end
      case (state)
        ST_IDLE: begin
          if (start_refresh) begin
            state      <= ST_REFRESH_ACTIVE;
            in_refresh <= 1'b1;
            timer      <= RAS_C8 - 8'h01;
          end else if (start_cpu) begin
            state      <= ST_ROW;
            in_refresh <= 1'b0;
            timer      <= MUX_C8;
            if (rmw_cycle_select) begin
              kind <= dram_ctrl_pkg::CYC_RMW;
            end else if (cpu_write) begin
              kind <= dram_ctrl_pkg::CYC_WRITE;
            end else begin
              kind <= dram_ctrl_pkg::CYC_READ;
            end
          end
        end
        ST_ROW: begin
          if (timer_done) begin
            state <= ST_COL;
            timer <= RCD_C8;
          end
        end
        ST_COL: begin
          if (timer_done) begin
            state <= ST_CAS;
            timer <= CAS_C8;
          end
        end
        ST_CAS: begin
          if (timer_done) begin
            if (kind == dram_ctrl_pkg::CYC_RMW) begin
              state <= ST_RMW_WR;
            end else begin
              state <= ST_ACK;
              timer <= ACK_C8;
            end
          end
        end
        ST_RMW_WR: begin
          // read half done; wait for the modified data before writing
          if (rmw_write_go) begin
            state <= ST_ACK;
            timer <= CAS_C8;
          end
        end
        ST_ACK: begin
          // ras held for its minimum and until the cpu has ended; a new request cannot stall here
          if (timer_done && !memory_ack) begin
            state <= ST_PRECHG;
            timer <= RP_C8 - 8'h01;
          end
        end
        ST_REFRESH_ACTIVE: begin
          if (timer_done) begin
            state <= ST_PRECHG;
            timer <= RP_C8 - 8'h01;
          end
        end
        ST_PRECHG: begin
          if (timer_done) begin
            state      <= ST_IDLE;
            in_refresh <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // refresh row counter wraps naturally at 2**ROW_BITS
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_row <= `ROW_RESET;
    end else if (state == ST_REFRESH_ACTIVE && timer_done) begin
      refresh_row <= refresh_row + ROW_BITS'(1);
    end
  end

  // dram strobes, registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dram <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 row_addr_gate: 1'b0, col_addr_gate: 1'b0, refresh_active: 1'b0};
    end else begin
      dram.ras_n <= !(state == ST_ROW || state == ST_COL || state == ST_CAS ||
                      state == ST_RMW_WR || state == ST_ACK || state == ST_REFRESH_ACTIVE);
      dram.cas_n <= !(state == ST_CAS || state == ST_RMW_WR || state == ST_ACK);
      dram.we_n  <= !((state == ST_ACK && kind == dram_ctrl_pkg::CYC_RMW) ||
                      ((state == ST_COL || state == ST_CAS || state == ST_ACK) &&
                       kind == dram_ctrl_pkg::CYC_WRITE));
      dram.row_addr_gate  <= (state == ST_ROW) || (state == ST_IDLE && start_cpu);
      dram.col_addr_gate  <= (state == ST_COL || state == ST_CAS ||
                              state == ST_RMW_WR || state == ST_ACK);
      dram.refresh_active <= in_refresh;
    end
  end

  // ack raised when data phase done, dropped once the cpu ends its cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_ack <= 1'b0;
    end else if (!cpu_level) begin
      memory_ack <= 1'b0;
    end else if ((state == ST_CAS && timer_done && kind != dram_ctrl_pkg::CYC_RMW) ||
                 (state == ST_RMW_WR && rmw_write_go)) begin
      memory_ack <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: testbench/dram_arb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dram_ctrl_cfg.svh"
module dram_arb_monitor #(
  parameter int ROW_BITS = 9
) (
  // clock and reset
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  // watched ports
  input wire logic                         cpu_mem_request,
  input wire logic                         memory_ack,
  input wire dram_ctrl_pkg::dram_strobes_t dram,
  input wire logic [ROW_BITS-1:0]          refresh_row
);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  // saturating, so a long ras low time never wraps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lo_cnt <= 8'h00;
    else if (dram.ras_n) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  // starts full: reset counts as precharge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hi_cnt <= 8'hff;
    else if (!dram.ras_n) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_REF_NO_CAS: assert property (dram.refresh_active |-> dram.cas_n)
    else $error("cas active in refresh");
  AST_ACK_NOT_REF: assert property (dram.refresh_active |-> !memory_ack)
    else $error("ack during refresh");
  AST_ROW_STEP: assert property ($changed(refresh_row) |-> refresh_row == $past(refresh_row) + 1'b1)
    else $error("refresh row jumped");
  AST_GATE_EXCL: assert property (!(dram.row_addr_gate && dram.col_addr_gate))
    else $error("both address gates on");
  AST_CAS_COL: assert property ($fell(dram.cas_n) |-> dram.col_addr_gate && !dram.ras_n)
    else $error("cas without column or ras");
  AST_RAS_WIDTH: assert property ($rose(dram.ras_n) |-> lo_cnt >= `RAS_CYC)
    else $error("ras low too short");
  AST_RP_WIDTH: assert property ($fell(dram.ras_n) |-> hi_cnt >= `RP_CYC)
    else $error("precharge too short");
  AST_REF_START: assert property ($rose(dram.refresh_active) |-> !dram.ras_n && dram.we_n)
    else $error("refresh without ras");
  AST_ACK_DROP: assert property (memory_ack && !cpu_mem_request |-> ##[1:6] !memory_ack)
    else $error("ack stuck");
  AST_ACK_HOLD: assert property (memory_ack && cpu_mem_request |=> memory_ack)
    else $error("ack dropped early");
  cover property ($rose(dram.refresh_active));
  cover property ($rose(memory_ack));
  cover property ($fell(dram.we_n));
endmodule
`default_nettype wire

// File: testbench/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input  wire logic core_clk,
  input  wire logic memory_ack,
  output logic      cpu_mem_request,
  output logic      cpu_write,
  output logic      rmw_cycle_select,
  output logic      rmw_write_go
);
  initial begin
    cpu_mem_request = 1'b0;
    cpu_write = 1'b0;
    rmw_cycle_select = 1'b0;
    rmw_write_go = 1'b0;
  end
  // slow sets when the write half of an rmw is released
  task automatic access(input dram_ctrl_pkg::cycle_kind_t k, input int slow, output int lat);
    int n;
    @(negedge core_clk);
    cpu_write = (k == dram_ctrl_pkg::CYC_WRITE);
    rmw_cycle_select = (k == dram_ctrl_pkg::CYC_RMW);
    cpu_mem_request = 1'b1;
    lat = -1;
    for (n = 0; n < 40000 && lat < 0; n++) begin
      @(negedge core_clk);
      if (rmw_cycle_select && n >= slow) rmw_write_go = 1'b1;
      if (memory_ack === 1'b1) lat = n;
    end
    // cpu may end its cycle a little after the ack
    repeat (slow % 3) @(negedge core_clk);
    cpu_mem_request = 1'b0;
    rmw_write_go = 1'b0;
    // idle qualifiers flip so no stale level looks valid
    cpu_write = ~cpu_write;
    rmw_cycle_select = ~rmw_cycle_select;
    for (n = 0; n < 20 && memory_ack === 1'b1; n++) @(negedge core_clk);
    if (memory_ack !== 1'b0) lat = -1;
  endtask
endmodule
`default_nettype wire

// File: testbench/dram_refresh_arbiter_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_arbiter_sequencer_tb;
  logic core_clk, rst_n, refresh_request_tick, burst_mode;
  wire logic cpu_mem_request, memory_ack, wr, rmw, go;
  dram_ctrl_pkg::dram_strobes_t dram;
  logic [8:0] row, r0;
  int n_fail, num_checks, n_ref, n_we, ref_at_ack, n0, w0, t;
  logic ra_q, we_q, ack_q;
  dram_refresh_arbiter_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n),
    .cpu_mem_request(cpu_mem_request), .cpu_write(wr), .rmw_cycle_select(rmw),
    .rmw_write_go(go), .memory_ack(memory_ack), .refresh_request_tick(refresh_request_tick),
    .burst_mode(burst_mode), .dram(dram), .refresh_row(row));
  cpu_bus_model cpu (.core_clk(core_clk), .memory_ack(memory_ack), .cpu_mem_request(cpu_mem_request),
    .cpu_write(wr), .rmw_cycle_select(rmw), .rmw_write_go(go));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {ra_q, we_q, ack_q} = 3'b010;
    {n_ref, n_we, ref_at_ack, n_fail, num_checks} = '0;
  end
  always @(negedge core_clk) begin
    if (dram.refresh_active && !ra_q) n_ref++;
    if (!dram.we_n && we_q) n_we++;
    if (memory_ack && !ack_q) ref_at_ack = n_ref;
    {ra_q, we_q, ack_q} = {dram.refresh_active, dram.we_n, memory_ack};
  end
  function automatic int exp_we(dram_ctrl_pkg::cycle_kind_t k);
    return (k == dram_ctrl_pkg::CYC_READ) ? 0 : 1;
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // off-grid edge: the tick source is asynchronous
  task automatic tick;
    @(negedge core_clk);
    #1.3 refresh_request_tick = 1'b1;
    repeat (4) @(negedge core_clk);
    refresh_request_tick = 1'b0;
  endtask
  task automatic do_acc(dram_ctrl_pkg::cycle_kind_t k, int slow);
    int lat;
    cpu.access(k, slow, lat);
    if (lat < 0) begin
      n_fail++;
      test_done;
    end
  endtask
  task automatic wait_ref(int want);
    for (int i = 0; i < 40000 && n_ref < want; i++) @(negedge core_clk);
    if (n_ref < want) begin
      n_fail++;
      test_done;
    end
  endtask
  initial begin
    void'($urandom(26138));
    {rst_n, refresh_request_tick, burst_mode} = 3'b000;
    repeat (12) @(negedge core_clk);
    chk("strobes in reset", 16'h0038, 16'(dram));
    chk("ack in reset", 16'h0000, 16'(memory_ack));
    chk("row in reset", 16'h0000, 16'(row));
    rst_n = 1'b1;
    for (int k = 0; k < 3; k++) begin
      w0 = n_we;
      do_acc(dram_ctrl_pkg::cycle_kind_t'(3'b001 << k), $urandom_range(0, 20));
      chk("write strobes", 16'(exp_we(dram_ctrl_pkg::cycle_kind_t'(3'b001 << k))), 16'(n_we - w0));
    end
    r0 = row;
    n0 = n_ref;
    tick;
    wait_ref(n0 + 1);
    repeat (60) @(negedge core_clk);
    chk("single refresh", 16'(n0 + 1), 16'(n_ref));
    chk("row advance", 16'(r0 + 9'h001), 16'(row));
    n0 = n_ref;
    fork
      do_acc(dram_ctrl_pkg::CYC_READ, 0);
      begin repeat (6) @(negedge core_clk); tick; end
    join
    chk("refresh held off", 16'(n0), 16'(ref_at_ack));
    wait_ref(n0 + 1);
    chk("held refresh", 16'(n0 + 1), 16'(n_ref));
    repeat (60) @(negedge core_clk);
    n0 = n_ref;
    fork
      tick;
      do_acc(dram_ctrl_pkg::CYC_WRITE, 0);
    join
    chk("tie to refresh", 16'(n0 + 1), 16'(ref_at_ack));
    repeat (60) @(negedge core_clk);
    burst_mode = 1'b1;
    r0 = row;
    n0 = n_ref;
    fork
      tick;
      begin repeat (20) @(negedge core_clk); do_acc(dram_ctrl_pkg::CYC_RMW, $urandom_range(0, 9)); end
    join
    burst_mode = 1'b0;
    chk("burst length", 16'(n0 + 512), 16'(ref_at_ack));
    chk("row wrap", 16'(r0), 16'(row));
    for (int i = 0; i < 6; i++) begin
      n0 = n_ref;
      t = $urandom_range(0, 1);
      fork
        if (t) tick;
        do_acc(dram_ctrl_pkg::cycle_kind_t'(3'b001 << $urandom_range(0, 2)), $urandom_range(0, 15));
      join
      repeat (80) @(negedge core_clk);
      chk("no lost refresh", 16'(n0 + t), 16'(n_ref));
    end
    test_done;
  end
endmodule
bind dram_refresh_arbiter_sequencer dram_arb_monitor #(.ROW_BITS(ROW_BITS)) mon (.core_clk(core_clk),
  .rst_n(rst_n), .cpu_mem_request(cpu_mem_request), .memory_ack(memory_ack), .dram(dram),
  .refresh_row(refresh_row));
`default_nettype wire
